/* File: verilog/mlcs_regs.vh */
`ifndef MLCS_REGS_VH
`define MLCS_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MLCS_OFF_CTRL      5'h00
`define MLCS_OFF_MODSRC    5'h04
`define MLCS_OFF_HCAR      5'h08
`define MLCS_OFF_LCAR      5'h0C
`define MLCS_OFF_CIN1PPS   5'h10
`define MLCS_OFF_CIN2PPS   5'h14
`define MLCS_OFF_MINPPS    5'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MLCS_CTRL_EN       7
`define MLCS_CTRL_OINV     4
`define MLCS_CTRL_OSTATE   3
`define MLCS_CTRL_SWBIT    0
`define MLCS_CAR_INV       6
`define MLCS_CAR_SYNC      5
`define MLCS_SEL_MSB       3
`define MLCS_PPS_MSB       4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MLCS_RST_BYTE      8'h00
`define MLCS_RST_SEL       4'h0
`define MLCS_RST_PPS       5'h00

// ----------------------------------------
// Carrier select codes
// ----------------------------------------
`define MLCS_CAR_VSS       4'h0
`define MLCS_CAR_CIN1      4'h1
`define MLCS_CAR_CIN2      4'h2
`define MLCS_CAR_REFCLK    4'h3
`define MLCS_CAR_CAP1      4'h4
`define MLCS_CAR_CAP2      4'h5
`define MLCS_CAR_PWM1      4'h6
`define MLCS_CAR_PWM2      4'h7
`define MLCS_CAR_NCO       4'h8
`define MLCS_CAR_NONE      4'h9
`define MLCS_CAR_SYSCLK    4'hA
`define MLCS_CAR_HFOSC     4'hB

`endif

/* File: verilog/mlcs_carrier_sel.v */
`timescale 1ns/100ps
`include "mlcs_regs.vh"
module mlcs_carrier_sel (
    src,
    sel,
    inv,
    carrier
);
    input  wire [15:0] src;
    input  wire [3:0]  sel;
    input  wire        inv;
    output wire        carrier;

    wire               picked;

    // Unused codes are tied low by the caller, so one index covers all sixteen
    assign picked  = src[sel];
    assign carrier = picked ^ inv;
endmodule // mlcs_carrier_sel

/* File: verilog/mlcs_mixer.v */
`timescale 1ns/100ps
`include "mlcs_regs.vh"
module mlcs_mixer (
    clk,
    nrst,
    enable,
    modSig,
    highCar,
    lowCar,
    highSync,
    lowSync,
    mixOut
);
    input  wire clk;
    input  wire nrst;
    input  wire enable;
    input  wire modSig;
    input  wire highCar;
    input  wire lowCar;
    input  wire highSync;
    input  wire lowSync;
    output wire mixOut;

    reg         selHigh_r;
    reg         selHigh_nxt;
    reg         highPrev_r;
    reg         lowPrev_r;
    wire        highFall;
    wire        lowFall;

    assign highFall = highPrev_r & ~highCar;
    assign lowFall  = lowPrev_r & ~lowCar;

    always @* begin
        selHigh_nxt = selHigh_r;
        if (!enable) begin
            // Track modulation while off so enabling starts on the right carrier
            selHigh_nxt = modSig;
        end else if (selHigh_r && !modSig) begin
            if (!highSync || highFall) begin
                selHigh_nxt = 1'b0;
            end
        end else if (!selHigh_r && modSig) begin
            if (!lowSync || lowFall) begin
                selHigh_nxt = 1'b1;
            end
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            selHigh_r  <= 1'b0;
            highPrev_r <= 1'b0;
            lowPrev_r  <= 1'b0;
        end else begin
            selHigh_r  <= selHigh_nxt;
            highPrev_r <= highCar;
            lowPrev_r  <= lowCar;
        end
    end

    assign mixOut = selHigh_nxt ? highCar : lowCar;
endmodule // mlcs_mixer

/* File: verilog/mlcs_top.v */
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/100ps
`include "mlcs_regs.vh"
module mlcs_top (
    clk,
    nrst,
    address,
    read,
    write,
    writedata,
    readdata,
    waitrequest,
    logicCellOut,
    hfOscIn,
    sysClkIn,
    ncoOut,
    pulseGenFirst,
    pulseGenSecond,
    captureUnitFirst,
    captureUnitSecond,
    refClkOut,
    uartTxOut,
    serialDataOut,
    comparatorOne,
    comparatorTwo,
    pinIn,
    modOut
);
    input  wire        clk;
    input  wire        nrst;
    input  wire [4:0]  address;
    input  wire        read;
    input  wire        write;
    input  wire [31:0] writedata;
    output wire [31:0] readdata;
    output wire        waitrequest;
    input  wire [3:0]  logicCellOut;
    input  wire        hfOscIn;
    input  wire        sysClkIn;
    input  wire        ncoOut;
    input  wire        pulseGenFirst;
    input  wire        pulseGenSecond;
    input  wire        captureUnitFirst;
    input  wire        captureUnitSecond;
    input  wire        refClkOut;
    input  wire        uartTxOut;
    input  wire        serialDataOut;
    input  wire        comparatorOne;
    input  wire        comparatorTwo;
    input  wire [31:0] pinIn;
    output wire        modOut;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg                modEnable_r;
    reg                outInvert_r;
    reg                swModValue_r;
    reg  [3:0]         modSelect_r;
    reg                highInvert_r;
    reg                highSyncEn_r;
    reg  [3:0]         highSelect_r;
    reg                lowInvert_r;
    reg                lowSyncEn_r;
    reg  [3:0]         lowSelect_r;
    reg  [4:0]         cin1Pps_r;
    reg  [4:0]         cin2Pps_r;
    reg  [4:0]         minPps_r;
    reg                outState_r;
    reg  [31:0]        readData_r;
    reg                waitReq_r;
    reg  [7:0]         readByte;

    wire               wrTake;
    wire [15:0]        carrierSrc;
    wire [15:0]        modSrc;
    wire               highCar;
    wire               lowCar;
    wire               modSig;
    wire               mixOut;
    wire               cin1Pin;
    wire               cin2Pin;
    wire               minPin;
    wire [7:0]         ctrlView;
    wire [7:0]         modSrcView;
    wire [7:0]         highCarView;
    wire [7:0]         lowCarView;
    wire [7:0]         cin1PpsView;
    wire [7:0]         cin2PpsView;
    wire [7:0]         minPpsView;
    reg                wrCtrl;
    reg                wrModSrc;
    reg                wrHighCar;
    reg                wrLowCar;
    reg                wrCin1Pps;
    reg                wrCin2Pps;
    reg                wrMinPps;

    // ----------------------------------------
    // Avalon-MM slave
    // ----------------------------------------
    // Fixed two-cycle access: the request is seen with waitrequest high, read
    // data is captured then, and the access completes on the following edge.
    assign wrTake = write && !waitReq_r;

    // Unimplemented bits are tied low here, so no write can ever show through
    assign ctrlView    = {modEnable_r, 2'b00, outInvert_r, outState_r, 2'b00, swModValue_r};
    assign modSrcView  = {4'h0, modSelect_r};
    assign highCarView = {1'b0, highInvert_r, highSyncEn_r, 1'b0, highSelect_r};
    assign lowCarView  = {1'b0, lowInvert_r, lowSyncEn_r, 1'b0, lowSelect_r};
    assign cin1PpsView = {3'h0, cin1Pps_r};
    assign cin2PpsView = {3'h0, cin2Pps_r};
    assign minPpsView  = {3'h0, minPps_r};

    always @* begin
        readByte = 8'h00;
        if (address == `MLCS_OFF_CTRL) begin
            readByte = ctrlView;
        end else if (address == `MLCS_OFF_MODSRC) begin
            readByte = modSrcView;
        end else if (address == `MLCS_OFF_HCAR) begin
            readByte = highCarView;
        end else if (address == `MLCS_OFF_LCAR) begin
            readByte = lowCarView;
        end else if (address == `MLCS_OFF_CIN1PPS) begin
            readByte = cin1PpsView;
        end else if (address == `MLCS_OFF_CIN2PPS) begin
            readByte = cin2PpsView;
        end else if (address == `MLCS_OFF_MINPPS) begin
            readByte = minPpsView;
        end else begin
            readByte = 8'h00;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            waitReq_r  <= 1'b1;
            readData_r <= 32'h00000000;
        end else begin
            if ((read || write) && waitReq_r) begin
                waitReq_r <= 1'b0;
                if (read) begin
                    readData_r <= {24'h000000, readByte};
                end
            end else begin
                waitReq_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // One strobe per register, so the register blocks below decode nothing
    always @* begin
        wrCtrl    = 1'b0;
        wrModSrc  = 1'b0;
        wrHighCar = 1'b0;
        wrLowCar  = 1'b0;
        wrCin1Pps = 1'b0;
        wrCin2Pps = 1'b0;
        wrMinPps  = 1'b0;
        if (wrTake) begin
            if (address == `MLCS_OFF_CTRL) begin
                wrCtrl = 1'b1;
            end else if (address == `MLCS_OFF_MODSRC) begin
                wrModSrc = 1'b1;
            end else if (address == `MLCS_OFF_HCAR) begin
                wrHighCar = 1'b1;
            end else if (address == `MLCS_OFF_LCAR) begin
                wrLowCar = 1'b1;
            end else if (address == `MLCS_OFF_CIN1PPS) begin
                wrCin1Pps = 1'b1;
            end else if (address == `MLCS_OFF_CIN2PPS) begin
                wrCin2Pps = 1'b1;
            end else if (address == `MLCS_OFF_MINPPS) begin
                wrMinPps = 1'b1;
            end
        end
    end

    // Output state bit is read-only, so it has no write path here
    always @(posedge clk) begin
        if (!nrst) begin
            modEnable_r  <= 1'b0;
            outInvert_r  <= 1'b0;
            swModValue_r <= 1'b0;
        end else if (wrCtrl) begin
            modEnable_r  <= writedata[`MLCS_CTRL_EN];
            outInvert_r  <= writedata[`MLCS_CTRL_OINV];
            swModValue_r <= writedata[`MLCS_CTRL_SWBIT];
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            modSelect_r <= `MLCS_RST_SEL;
        end else if (wrModSrc) begin
            modSelect_r <= writedata[`MLCS_SEL_MSB:0];
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            highInvert_r <= 1'b0;
            highSyncEn_r <= 1'b0;
            highSelect_r <= `MLCS_RST_SEL;
        end else if (wrHighCar) begin
            highInvert_r <= writedata[`MLCS_CAR_INV];
            highSyncEn_r <= writedata[`MLCS_CAR_SYNC];
            highSelect_r <= writedata[`MLCS_SEL_MSB:0];
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            lowInvert_r <= 1'b0;
            lowSyncEn_r <= 1'b0;
            lowSelect_r <= `MLCS_RST_SEL;
        end else if (wrLowCar) begin
            lowInvert_r <= writedata[`MLCS_CAR_INV];
            lowSyncEn_r <= writedata[`MLCS_CAR_SYNC];
            lowSelect_r <= writedata[`MLCS_SEL_MSB:0];
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            cin1Pps_r <= `MLCS_RST_PPS;
        end else if (wrCin1Pps) begin
            cin1Pps_r <= writedata[`MLCS_PPS_MSB:0];
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            cin2Pps_r <= `MLCS_RST_PPS;
        end else if (wrCin2Pps) begin
            cin2Pps_r <= writedata[`MLCS_PPS_MSB:0];
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            minPps_r <= `MLCS_RST_PPS;
        end else if (wrMinPps) begin
            minPps_r <= writedata[`MLCS_PPS_MSB:0];
        end
    end

    // ----------------------------------------
    // Source routing
    // ----------------------------------------
    assign cin1Pin = pinIn[cin1Pps_r];
    assign cin2Pin = pinIn[cin2Pps_r];
    assign minPin  = pinIn[minPps_r];

    // Capture-unit taps are passed raw; they only make sense in pulse-width mode
    assign carrierSrc = {logicCellOut[3], logicCellOut[2], logicCellOut[1], logicCellOut[0],
                         hfOscIn, sysClkIn,
                         1'b0,
                         ncoOut, pulseGenSecond, pulseGenFirst,
                         captureUnitSecond, captureUnitFirst,
                         refClkOut, cin2Pin, cin1Pin,
                         1'b0};

    assign modSrc = {logicCellOut[3], logicCellOut[2], logicCellOut[1], logicCellOut[0],
                     ncoOut, uartTxOut, 1'b0, serialDataOut,
                     comparatorTwo, comparatorOne, pulseGenSecond, pulseGenFirst,
                     captureUnitSecond, captureUnitFirst, minPin, swModValue_r};

    assign modSig = modSrc[modSelect_r];

    mlcs_carrier_sel uHighSel (
        .src     (carrierSrc),
        .sel     (highSelect_r),
        .inv     (highInvert_r),
        .carrier (highCar)
    );

    mlcs_carrier_sel uLowSel (
        .src     (carrierSrc),
        .sel     (lowSelect_r),
        .inv     (lowInvert_r),
        .carrier (lowCar)
    );

    mlcs_mixer uMixer (
        .clk      (clk),
        .nrst     (nrst),
        .enable   (modEnable_r),
        .modSig   (modSig),
        .highCar  (highCar),
        .lowCar   (lowCar),
        .highSync (highSyncEn_r),
        .lowSync  (lowSyncEn_r),
        .mixOut   (mixOut)
    );

    // ----------------------------------------
    // Output stage
    // ----------------------------------------
    // Registered for a clean pin; costs one cycle of carrier latency
    always @(posedge clk) begin
        if (!nrst) begin
            outState_r <= 1'b0;
        end else if (modEnable_r) begin
            outState_r <= mixOut ^ outInvert_r;
        end else begin
            outState_r <= outInvert_r;
        end
    end

    assign modOut      = outState_r;
    assign readdata    = readData_r;
    assign waitrequest = waitReq_r;
endmodule // mlcs_top

/* File: tb/mlcs_src_model.sv */
`timescale 1ns/100ps
module mlcs_src_model #(
    parameter PIN1 = 5,
    parameter PIN2 = 9
) (
    input  wire [3:0]  code,
    input  wire        level,
    output reg  [15:0] car,
    output reg  [31:0] pins
);
    // ----------------------------------------
    // Source levels
    // ----------------------------------------
    // Unselected sources show the opposite level, so a wrong pick shows up
    always @* begin
        car = {16{~level}};
        pins = {32{~level}};
        car[code] = level;
        if (code == 4'h1) begin
            pins[PIN1] = level;
        end
        if (code == 4'h2) begin
            pins[PIN2] = level;
        end
    end
endmodule // mlcs_src_model

/* File: tb/mlcs_top_assertions.sv */
`timescale 1ns/100ps
module mlcs_top_assertions (
    input wire        clk,
    input wire        nrst,
    input wire [4:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire [31:0] readdata,
    input wire        waitrequest,
    input wire        modOut
);
    reg [7:0] lowShadow_r;
    reg       enShadow_r;
    reg       oinvShadow_r;
    always @(posedge clk) begin
        if (!nrst) begin
            lowShadow_r <= 8'h00;
            enShadow_r <= 1'b0;
            oinvShadow_r <= 1'b0;
        end else if (write && !waitrequest) begin
            if (address == 5'h0C) begin
                lowShadow_r <= writedata[7:0] & 8'h6F;
            end
            if (address == 5'h00) begin
                enShadow_r <= writedata[7];
                oinvShadow_r <= writedata[4];
            end
        end
    end
    a_wait_single: assert property (@(posedge clk) disable iff (!nrst)
        !waitrequest |=> waitrequest) else $error("waitrequest low too long");
    a_wait_answer: assert property (@(posedge clk) disable iff (!nrst)
        (read || write) && waitrequest |=> !waitrequest) else $error("no answer");
    a_idle_quiet: assert property (@(posedge clk) disable iff (!nrst)
        !read && !write |=> waitrequest) else $error("answer without request");
    a_reset_quiet: assert property (@(posedge clk)
        !nrst |=> waitrequest && readdata == 32'h0 && !modOut) else $error("reset state wrong");
    a_low_readback: assert property (@(posedge clk) disable iff (!nrst)
        read && waitrequest && address == 5'h0C |=> readdata[7:0] == lowShadow_r) else $error("readback");
    a_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst)
        read && waitrequest && address > 5'h18 |=> readdata == 32'h0) else $error("unmapped read");
    a_upper_zero: assert property (@(posedge clk) disable iff (!nrst)
        !waitrequest |-> readdata[31:8] == 24'h0) else $error("upper read bits");
    a_disabled_idle: assert property (@(posedge clk) disable iff (!nrst)
        !enShadow_r |=> modOut == $past(oinvShadow_r)) else $error("idle level");
endmodule // mlcs_top_assertions
bind mlcs_top mlcs_top_assertions u_mlcs_top_assertions (.clk(clk), .nrst(nrst), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .modOut(modOut));

/* File: tb/modulator_low_carrier_select_tb_top.sv */
`timescale 1ns/100ps
module modulator_low_carrier_select_tb_top;
    reg         clk;
    reg         nrst;
    reg  [4:0]  address;
    reg         read;
    reg         write;
    reg  [31:0] writedata;
    wire [31:0] readdata;
    wire        waitrequest;
    wire        modOut;
    reg  [3:0]  srcCode;
    reg         srcLevel;
    wire [15:0] car;
    wire [31:0] pins;
    reg  [7:0]  rdVal;
    integer     errTotal;
    integer     nTests;
    integer     cycles;
    mlcs_top u_mlcs_top (.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .logicCellOut(car[15:12]), .hfOscIn(car[11]), .sysClkIn(car[10]), .ncoOut(car[8]),
        .pulseGenFirst(car[6]), .pulseGenSecond(car[7]), .captureUnitFirst(car[4]),
        .captureUnitSecond(car[5]), .refClkOut(car[3]), .uartTxOut(car[9]), .serialDataOut(car[9]),
        .comparatorOne(car[0]), .comparatorTwo(car[0]), .pinIn(pins), .modOut(modOut));
    mlcs_src_model u_mlcs_src_model (.code(srcCode), .level(srcLevel), .car(car), .pins(pins));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task printVerdict;
        begin
            if (errTotal == 0 && nTests > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            errTotal = errTotal + 1;
            printVerdict;
        end
    end
    task check(input [31:0] got, input [31:0] exp);
        begin
            nTests = nTests + 1;
            if (got !== exp) begin
                errTotal = errTotal + 1;
                $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
            end
        end
    endtask
    task busWrite(input [4:0] a, input [7:0] d);
        begin
            @(posedge clk);
            address <= a;
            writedata <= {24'h0, d};
            write <= 1'b1;
            @(posedge clk);
            while (waitrequest !== 1'b0) @(posedge clk);
            write <= 1'b0;
        end
    endtask
    task busRead(input [4:0] a, output [7:0] d);
        begin
            @(posedge clk);
            address <= a;
            read <= 1'b1;
            @(posedge clk);
            while (waitrequest !== 1'b0) @(posedge clk);
            d = readdata[7:0];
            read <= 1'b0;
        end
    endtask
    // Source change, then time for the registered output to follow
    task setSrc(input [3:0] c, input l);
        begin
            @(posedge clk);
            srcCode <= c;
            srcLevel <= l;
            repeat (3) @(posedge clk);
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task testReset;
        integer i;
        begin
            check(modOut, 1'b0);
            for (i = 0; i < 8; i = i + 1) begin
                busRead({i[2:0], 2'b00}, rdVal);
                check(rdVal, 8'h00);
            end
        end
    endtask
    task testUnimpl;
        begin
            busWrite(5'h0C, 8'hFF);
            busRead(5'h0C, rdVal);
            check(rdVal, 8'h6F);
        end
    endtask
    task testMap;
        integer c;
        integer k;
        begin
            busWrite(5'h00, 8'h80);
            for (c = 0; c < 16; c = c + 1) begin
                for (k = 0; k < 4; k = k + 1) begin
                    busWrite(5'h0C, {1'b0, k[1], 2'b00, c[3:0]});
                    setSrc(c[3:0], k[0]);
                    check(modOut, (c == 0 || c == 9) ? k[1] : k[0] ^ k[1]);
                end
            end
        end
    endtask
    task testIdle;
        begin
            setSrc(4'hF, 1'b1);
            busWrite(5'h0C, 8'h0F);
            busWrite(5'h00, 8'h10);
            repeat (3) @(posedge clk);
            check(modOut, 1'b1);
            busWrite(5'h00, 8'h00);
            repeat (3) @(posedge clk);
            check(modOut, 1'b0);
            busWrite(5'h00, 8'h90);
            repeat (3) @(posedge clk);
            check(modOut, 1'b0);
        end
    endtask
    task testSync;
        begin
            busWrite(5'h08, 8'h40);
            busWrite(5'h0C, 8'h2F);
            setSrc(4'hF, 1'b0);
            busWrite(5'h00, 8'h80);
            busWrite(5'h00, 8'h81);
            repeat (4) @(posedge clk);
            check(modOut, 1'b0);
            setSrc(4'hF, 1'b1);
            check(modOut, 1'b1);
            setSrc(4'hF, 1'b0);
            check(modOut, 1'b1);
            busWrite(5'h00, 8'h80);
            repeat (3) @(posedge clk);
            check(modOut, 1'b0);
            busWrite(5'h0C, 8'h0F);
            busWrite(5'h00, 8'h81);
            repeat (3) @(posedge clk);
            check(modOut, 1'b1);
        end
    endtask
    // High carrier held until its own falling edge, low carrier tied to ground
    task testHighSync;
        begin
            busWrite(5'h0C, 8'h00);
            busWrite(5'h08, 8'h2F);
            setSrc(4'hF, 1'b1);
            check(modOut, 1'b1);
            busWrite(5'h00, 8'h80);
            repeat (3) @(posedge clk);
            check(modOut, 1'b1);
            setSrc(4'hF, 1'b0);
            setSrc(4'hF, 1'b1);
            check(modOut, 1'b0);
        end
    endtask
    // Modulation taken from a pin through its pin select
    task testModSrc;
        begin
            busWrite(5'h18, 8'h05);
            busRead(5'h18, rdVal);
            check(rdVal, 8'h05);
            busWrite(5'h04, 8'h01);
            busWrite(5'h0C, 8'h00);
            busWrite(5'h08, 8'h40);
            busWrite(5'h00, 8'h80);
            setSrc(4'h1, 1'b1);
            check(modOut, 1'b1);
            setSrc(4'h1, 1'b0);
            check(modOut, 1'b0);
        end
    endtask
    initial begin
        nrst = 1'b0;
        address = 5'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        srcCode = 4'h0;
        srcLevel = 1'b0;
        errTotal = 0;
        nTests = 0;
        cycles = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        testReset;
        busWrite(5'h10, 8'h05);
        busWrite(5'h14, 8'h09);
        testUnimpl;
        testMap;
        testIdle;
        testSync;
        testHighSync;
        testModSrc;
        printVerdict;
    end
endmodule // modulator_low_carrier_select_tb_top
